// *** logic/dpt_pkg.sv ***
// ==========================================================
// shared constants and carriers for the dual down timer
package dpt_pkg;

  // ==========================================================
  // bus geometry
  localparam int          ADDR_W   = 12;
  localparam int          DATA_W   = 32;
  localparam int          NUM_TMR  = 2;
  localparam logic [1:0]  RESP_OKAY   = 2'h0;
  localparam logic [1:0]  RESP_SLVERR = 2'h2;

  // ==========================================================
  // register indices, byte address is four times the index
  localparam logic [9:0]  IDX_A_PSC    = 10'h0d2;
  localparam logic [9:0]  IDX_A_CNT    = 10'h0d3;
  localparam logic [9:0]  IDX_A_CTL    = 10'h0d4;
  localparam logic [9:0]  IDX_B_PSC    = 10'h0d5;
  localparam logic [9:0]  IDX_B_CNT    = 10'h0d6;
  localparam logic [9:0]  IDX_B_CTL    = 10'h0d7;
  localparam logic [9:0]  IDX_IRQ_STAT = 10'h0d8;
  localparam logic [9:0]  IDX_IRQ_MASK = 10'h0d9;

  // slot numbers relative to the first index
  localparam logic [2:0]  SLOT_PSC  = 3'h0;
  localparam logic [2:0]  SLOT_CNT  = 3'h1;
  localparam logic [2:0]  SLOT_CTL  = 3'h2;
  localparam logic [2:0]  SLOT_PER  = 3'h3;
  localparam logic [2:0]  SLOT_STAT = 3'h6;
  localparam logic [2:0]  SLOT_MASK = 3'h7;

  // ==========================================================
  // control/status field positions
  localparam int          CTL_ZERO_BIT  = 7;
  localparam int          CTL_IRQEN_BIT = 6;
  localparam int          CTL_RUN_BIT   = 3;
  localparam int          CTL_TAP_MSB   = 2;

  // ==========================================================
  // reset and forced values
  localparam logic [6:0]  PSC_RESET      = 7'h7f;
  localparam logic [6:0]  PSC_STOP_VALUE = 7'h7f;
  localparam logic [7:0]  CNT_RESET      = 8'hff;
  localparam logic [7:0]  CTL_RESET      = 8'h00;
  localparam logic [1:0]  IRQ_MASK_RESET = 2'h0;

  // ==========================================================
  // core clock divider feeding every prescaler
  localparam int          FINT_DIV = 12;
  localparam logic [3:0]  DIV_LAST = 4'(FINT_DIV - 1);

  // ==========================================================
  // carriers between top and timer unit
  typedef struct packed {
    logic       timer_a_prescaler_value;
    logic       cnt;
    logic       ctl;
    logic [7:0] data;
  } dpt_wr_t;

  typedef struct packed {
    logic [6:0] timer_a_prescaler_value;
    logic [7:0] cnt;
    logic [7:0] ctl;
  } dpt_rd_t;

  typedef struct packed {
    logic       hit;
    logic [2:0] slot;
  } dpt_dec_t;

endpackage

// *** logic/dpt_timer_top.sv ***
// Added by the designer: the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
// What this block does
// RULE1: two independent timers, each with own counter, prescaler, control registers.
// RULE2: eight-bit count decrements once per rising edge of selected prescaler tap.
// RULE3: seven-bit prescaler counts down on core clock divided by twelve.
// RULE4: factor one uses prescaler input; factor two bit zero; and upward.
// RULE5: three-bit tap code 000..111 selects division 1 to 128.
// RULE6: run bit low forces prescaler to 7Fh and stops both counters.
// RULE7: while running, software may load prescaler with any 0..7Fh value.
// RULE8: count reaching zero sets sticky zero flag, bit 7, until cleared.
// RULE9: writing 00h to count or 1 to bit 7 also sets flag.
// RULE10: interrupt request raised while enable bit 6 and zero flag both set.
// RULE11: timer request doubles as wake-up from the low-power wait state.
// RULE12: software clears zero flag before returning and before a new count.
// RULE13: reset loads count FFh, prescaler 7Fh, clears control: stopped, quiet.
// RULE14: count write beats simultaneous decrement to zero; no flag from it.
// RULE15: count and prescaler reads always return the exact current values.
// RULE16: prescaler register shows state in bits 6..0, bit 7 reads zero.
// RULE17: software writes one to control bit 5; bit 4 is free.
// RULE18: interrupt request is a level held while enable and flag stay set.
module dpt_timer_top
  import dpt_pkg::*;
(
  // clock and reset
  input  wire logic                aclk,
  input  wire logic                aresetn,
  // write address channel
  input  wire logic [ADDR_W-1:0]   s_axi_awaddr,
  input  wire logic [2:0]          s_axi_awprot,
  input  wire logic                s_axi_awvalid,
  output logic                     s_axi_awready,
  // write data channel
  input  wire logic [DATA_W-1:0]   s_axi_wdata,
  input  wire logic [DATA_W/8-1:0] s_axi_wstrb,
  input  wire logic                s_axi_wvalid,
  output logic                     s_axi_wready,
  // write response channel
  output logic [1:0]               s_axi_bresp,
  output logic                     s_axi_bvalid,
  input  wire logic                s_axi_bready,
  // read address channel
  input  wire logic [ADDR_W-1:0]   s_axi_araddr,
  input  wire logic [2:0]          s_axi_arprot,
  input  wire logic                s_axi_arvalid,
  output logic                     s_axi_arready,
  // read data channel
  output logic [DATA_W-1:0]        s_axi_rdata,
  output logic [1:0]               s_axi_rresp,
  output logic                     s_axi_rvalid,
  input  wire logic                s_axi_rready,
  // requests
  output logic [NUM_TMR-1:0]       timer_irq,
  output logic                     wake_req,
  output logic                     irq
);

  // ==========================================================
  // address decode shared by read and write paths
  function automatic dpt_dec_t dpt_decode(input logic [ADDR_W-1:0] addr);
    logic [9:0] idx;
    logic [9:0] rel;
    idx = addr[ADDR_W-1:2];
    rel = 10'(idx - IDX_A_PSC);
    dpt_decode.hit  = (idx >= IDX_A_PSC) && (idx <= IDX_IRQ_MASK);
    dpt_decode.slot = rel[2:0];
  endfunction

  // ==========================================================
  // bus slave state
  logic [ADDR_W-1:0] awaddr_reg;
  logic [DATA_W-1:0] wdata_reg;
  logic              wstrb0_reg;
  logic              awready_reg;
  logic              wready_reg;
  logic              bvalid_reg;
  logic [1:0]        bresp_reg;
  logic              arready_reg;
  logic              rvalid_reg;
  logic [1:0]        rresp_reg;
  logic [DATA_W-1:0] rdata_reg;

  // handshakes and decoded targets
  logic              aw_hs;
  logic              w_hs;
  logic              b_hs;
  logic              ar_hs;
  logic              r_hs;
  logic              wr_fire;
  logic              wr_ok;
  dpt_dec_t          dec_w;
  dpt_dec_t          dec_r;

  // ==========================================================
  // divider, timers and interrupt state
  logic [3:0]        div_reg;
  logic              tick_reg;
  dpt_wr_t           wr_bus  [NUM_TMR];
  dpt_rd_t           rd_bus  [NUM_TMR];
  logic [NUM_TMR-1:0] req;
  logic [NUM_TMR-1:0] req_prev_reg;
  logic [NUM_TMR-1:0] req_rise;
  logic [NUM_TMR-1:0] stat_reg;
  logic [NUM_TMR-1:0] stat_next;
  logic [NUM_TMR-1:0] stat_clr;
  logic [NUM_TMR-1:0] mask_reg;
  logic [NUM_TMR-1:0] mask_next;
  logic [7:0]        rd_bank [8];
  logic              irq_reg;
  logic              wake_reg;

  // ==========================================================
  // channel handshakes
  assign aw_hs = s_axi_awvalid & awready_reg;
  assign w_hs  = s_axi_wvalid & wready_reg;
  assign b_hs  = bvalid_reg & s_axi_bready;
  assign ar_hs = s_axi_arvalid & arready_reg;
  assign r_hs  = rvalid_reg & s_axi_rready;

  // write acts once both halves are held and no response pends
  assign wr_fire = ~awready_reg & ~wready_reg & ~bvalid_reg;
  assign dec_w   = dpt_decode(awaddr_reg);
  assign dec_r   = dpt_decode(s_axi_araddr);
  // low byte lane carries every register
  assign wr_ok   = wr_fire & dec_w.hit & wstrb0_reg;

  // ==========================================================
  // write address capture, ready drops while held
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awready_reg <= 1'b1;
      awaddr_reg  <= '0;
    end else if (aw_hs) begin
      awready_reg <= 1'b0;
      awaddr_reg  <= s_axi_awaddr;
    end else if (b_hs) begin
      awready_reg <= 1'b1;
    end
  end

  // write data capture
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wready_reg <= 1'b1;
      wdata_reg  <= '0;
      wstrb0_reg <= 1'b0;
    end else if (w_hs) begin
      wready_reg <= 1'b0;
      wdata_reg  <= s_axi_wdata;
      wstrb0_reg <= s_axi_wstrb[0];
    end else if (b_hs) begin
      wready_reg <= 1'b1;
    end
  end

  // write response, error for unmapped words
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid_reg <= 1'b0;
      bresp_reg  <= RESP_OKAY;
    end else if (wr_fire) begin
      bvalid_reg <= 1'b1;
      bresp_reg  <= dec_w.hit ? RESP_OKAY : RESP_SLVERR;
    end else if (b_hs) begin
      bvalid_reg <= 1'b0;
    end
  end

  // ==========================================================
  // read channel, one beat after the address is taken
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready_reg <= 1'b1;
      rvalid_reg  <= 1'b0;
      rresp_reg   <= RESP_OKAY;
      rdata_reg   <= '0;
    end else if (ar_hs) begin
      arready_reg <= 1'b0;
      rvalid_reg  <= 1'b1;
      rresp_reg   <= dec_r.hit ? RESP_OKAY : RESP_SLVERR;
      rdata_reg   <= dec_r.hit ? {24'h00_0000, rd_bank[dec_r.slot]} : '0;
    end else if (r_hs) begin
      arready_reg <= 1'b1;
      rvalid_reg  <= 1'b0;
    end
  end

  // ==========================================================
  // core clock divided by twelve as a one-cycle enable
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      div_reg  <= 4'h0;
      tick_reg <= 1'b0;
    end else begin
      div_reg  <= (div_reg == DIV_LAST) ? 4'h0 : 4'(div_reg + 4'h1);  // [RULE3]
      tick_reg <= (div_reg == DIV_LAST);
    end
  end

  // ==========================================================
  // two separate timers, each with its own register slots
  for (genvar i = 0; i < NUM_TMR; i++) begin : g_tmr
    localparam logic [2:0] BASE = 3'(i * 3);

    // per-timer write strobes
    assign wr_bus[i].timer_a_prescaler_value  = wr_ok & (dec_w.slot == 3'(BASE + SLOT_PSC));  // [RULE1]
    assign wr_bus[i].cnt  = wr_ok & (dec_w.slot == 3'(BASE + SLOT_CNT));
    assign wr_bus[i].ctl  = wr_ok & (dec_w.slot == 3'(BASE + SLOT_CTL));
    assign wr_bus[i].data = wdata_reg[7:0];

    dpt_timer_unit u_tmr (
      .aclk          (aclk),
      .aresetn       (aresetn),
      .prescale_tick (tick_reg),
      .wr            (wr_bus[i]),
      .rd            (rd_bus[i]),
      .irq_req       (req[i])
    );

    // read bytes, prescaler bit 7 always zero
    assign rd_bank[BASE + SLOT_PSC] = {1'b0, rd_bus[i].timer_a_prescaler_value};          // [RULE16]
    assign rd_bank[BASE + SLOT_CNT] = rd_bus[i].cnt;                   // [RULE15]
    assign rd_bank[BASE + SLOT_CTL] = rd_bus[i].ctl;
  end

  // status and mask read back
  assign rd_bank[SLOT_STAT] = {6'h00, stat_reg};
  assign rd_bank[SLOT_MASK] = {6'h00, mask_reg};

  // ==========================================================
  // interrupt status: sticky, write one to clear, set wins
  assign req_rise  = req & ~req_prev_reg;
  assign stat_clr  = (wr_ok && dec_w.slot == SLOT_STAT) ? wdata_reg[1:0] : 2'h0;
  assign stat_next = (stat_reg & ~stat_clr) | req_rise;
  assign mask_next = (wr_ok && dec_w.slot == SLOT_MASK) ? wdata_reg[1:0] : mask_reg;

  // status, mask and request outputs
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      req_prev_reg <= 2'h0;
      stat_reg     <= 2'h0;
      mask_reg     <= IRQ_MASK_RESET;
      irq_reg      <= 1'b0;
      wake_reg     <= 1'b0;
    end else begin
      req_prev_reg <= req;
      stat_reg     <= stat_next;
      mask_reg     <= mask_next;
      irq_reg      <= |(stat_next & mask_next);
      wake_reg     <= |req;                                            // [RULE11]
    end
  end

  // ==========================================================
  // port drivers
  assign s_axi_awready = awready_reg;
  assign s_axi_wready  = wready_reg;
  assign s_axi_bvalid  = bvalid_reg;
  assign s_axi_bresp   = bresp_reg;
  assign s_axi_arready = arready_reg;
  assign s_axi_rvalid  = rvalid_reg;
  assign s_axi_rresp   = rresp_reg;
  assign s_axi_rdata   = rdata_reg;
  assign timer_irq     = req;                                          // [RULE10] [RULE18]
  assign wake_req      = wake_reg;
  assign irq           = irq_reg;

endmodule

// *** logic/dpt_timer_unit.sv ***
`timescale 1ns/1ps
// ==========================================================
// one timer: prescaler, down counter and control/status
module dpt_timer_unit
  import dpt_pkg::*;
(
  // clock and reset
  input  wire logic    aclk,
  input  wire logic    aresetn,
  // divided core clock enable
  input  wire logic    prescale_tick,
  // register access
  input  wire dpt_wr_t wr,
  output dpt_rd_t      rd,
  // request level
  output logic         irq_req
);

  logic [6:0] psc_reg;
  logic [6:0] psc_next;
  logic [7:0] cnt_reg;
  logic [7:0] cnt_next;
  logic [7:0] ctl_reg;
  logic [7:0] ctl_next;
  logic [7:0] ctl_base;
  logic [7:0] tap_span;
  logic [6:0] tap_mask;
  logic       run;
  logic       cnt_tick;
  logic       hw_zero;

  // ==========================================================
  // tap selection
  assign run      = ctl_reg[CTL_RUN_BIT];
  // low bits that must all be zero before the tapped bit rises
  assign tap_span = 8'(8'h01 << ctl_reg[CTL_TAP_MSB:0]);              // [RULE5]
  assign tap_mask = 7'(tap_span - 8'h01);
  // tapped prescaler bit rises when its lower bits wrap from zero
  assign cnt_tick = run & prescale_tick & ~wr.timer_a_prescaler_value
                  & ((psc_reg & tap_mask) == 7'h00);                   // [RULE2] [RULE4]

  // ==========================================================
  // prescaler: forced while stopped, loadable while running
  assign psc_next = !run         ? PSC_STOP_VALUE :                    // [RULE6]
                    wr.timer_a_prescaler_value        ? wr.data[6:0] :                      // [RULE7]
                    prescale_tick ? 7'(psc_reg - 7'h01) :               // [RULE3]
                                    psc_reg;

  // ==========================================================
  // counter: a software write beats the decrement
  assign cnt_next = wr.cnt   ? wr.data :                               // [RULE14]
                    cnt_tick ? 8'(cnt_reg - 8'h01) :                    // [RULE2]
                               cnt_reg;
  // zero reached by count or by writing zero
  assign hw_zero  = wr.cnt ? (wr.data == 8'h00)                        // [RULE9] [RULE14]
                           : (cnt_tick && cnt_reg == 8'h01);           // [RULE8]

  // ==========================================================
  // control: flag is sticky, hardware set wins over clear
  assign ctl_base = wr.ctl ? wr.data : ctl_reg;
  assign ctl_next = {ctl_base[7] | hw_zero, ctl_base[6:0]};            // [RULE8] [RULE9]

  // registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      psc_reg <= PSC_RESET;                                             // [RULE13]
      cnt_reg <= CNT_RESET;
      ctl_reg <= CTL_RESET;
      irq_req <= 1'b0;
    end else begin
      psc_reg <= psc_next;
      cnt_reg <= cnt_next;
      ctl_reg <= ctl_next;
      irq_req <= ctl_next[CTL_ZERO_BIT] & ctl_next[CTL_IRQEN_BIT];      // [RULE10] [RULE18]
    end
  end

  // live values for reads
  assign rd = '{timer_a_prescaler_value: psc_reg, cnt: cnt_reg, ctl: ctl_reg};             // [RULE15]

endmodule

// *** testbench/dpt_timer_checker.sv ***
`timescale 1ns/1ps
// ==========================================================
// port checks for the dual down timer
module dpt_timer_checker
  import dpt_pkg::*;
(
  // clock and reset
  input wire logic                aclk,
  input wire logic                aresetn,
  // write side
  input wire logic                s_axi_awvalid,
  input wire logic                s_axi_awready,
  input wire logic                s_axi_wvalid,
  input wire logic                s_axi_wready,
  input wire logic [1:0]          s_axi_bresp,
  input wire logic                s_axi_bvalid,
  input wire logic                s_axi_bready,
  // read side
  input wire logic [ADDR_W-1:0]   s_axi_araddr,
  input wire logic                s_axi_arvalid,
  input wire logic                s_axi_arready,
  input wire logic [DATA_W-1:0]   s_axi_rdata,
  input wire logic [1:0]          s_axi_rresp,
  input wire logic                s_axi_rvalid,
  input wire logic                s_axi_rready,
  // requests
  input wire logic [NUM_TMR-1:0]  timer_irq,
  input wire logic                wake_req
);
  logic [9:0] ar_idx_reg;
  logic       psc_hit;
  logic       unmapped;

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  // index of the read in flight
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ar_idx_reg <= 10'h000;
    end else if (s_axi_arvalid && s_axi_arready) begin
      ar_idx_reg <= s_axi_araddr[11:2];
    end
  end
  // decode of that index
  assign psc_hit  = (ar_idx_reg == IDX_A_PSC) || (ar_idx_reg == IDX_B_PSC);
  assign unmapped = (ar_idx_reg < IDX_A_PSC) || (ar_idx_reg > IDX_IRQ_MASK);

  // write acts the cycle after both halves are held, answer stands from the edge after that
  a_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
    |-> ##2 s_axi_bvalid) else $error("late write answer");
  a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("late read answer");
  a_b_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write answer dropped");
  a_r_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read answer dropped");
  a_ready_low: assert property (s_axi_bvalid || s_axi_rvalid |->
    !(s_axi_bvalid && (s_axi_awready || s_axi_wready)) && !(s_axi_rvalid && s_axi_arready))
    else $error("ready high while answer pending");
  a_read_resp: assert property (s_axi_rvalid |-> s_axi_rresp == (unmapped ? RESP_SLVERR : RESP_OKAY)
    && (!unmapped || s_axi_rdata == 32'h0000_0000)) else $error("bad read response");
  a_psc_msb: assert property (s_axi_rvalid && psc_hit |-> s_axi_rdata[7] == 1'b0)
    else $error("prescaler top bit set");
  a_wake_follow: assert property (##1 wake_req == $past(|timer_irq))
    else $error("wake does not follow request");
  a_irq_fall: assert property (|($past(timer_irq) & ~timer_irq) |-> $rose(s_axi_bvalid))
    else $error("request dropped without write");
  a_reset_quiet: assert property ($rose(aresetn) |-> timer_irq == 2'h0 && !wake_req)
    else $error("request after reset");
endmodule

// *** testbench/tb.sv ***
`timescale 1ns/1ps
// ==========================================================
// register-level bench for the dual down timer
module tb;
  import dpt_pkg::*;
  // bus and request signals
  logic        aclk          = 1'b0;
  logic        aresetn       = 1'b0;
  logic [11:0] s_axi_awaddr  = 12'h000;
  logic [11:0] s_axi_araddr  = 12'h000;
  logic [31:0] s_axi_wdata   = 32'h0000_0000;
  logic        s_axi_awvalid = 1'b0;
  logic        s_axi_wvalid  = 1'b0;
  logic        s_axi_bready  = 1'b0;
  logic        s_axi_arvalid = 1'b0;
  logic        s_axi_rready  = 1'b0;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, wake_req, irq;
  logic [1:0]  s_axi_bresp, s_axi_rresp, timer_irq, r;
  logic [31:0] s_axi_rdata, v;
  int          n_mismatch    = 0;
  int          n_checks      = 0;
  int          k;

  // 40 MHz clock
  always #12.5 aclk = ~aclk;

  dpt_timer_top uut (
    .aclk, .aresetn, .s_axi_awaddr, .s_axi_awprot(3'h0), .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb(4'hf), .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arprot(3'h0), .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .timer_irq, .wake_req, .irq
  );

  // ==========================================================
  // helpers
  function automatic logic [9:0] ix(input int t, input logic [2:0] s);
    return 10'(IDX_A_PSC + 3 * t + s);
  endfunction

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [9:0] i, input logic [31:0] d);
    logic a_ok;
    logic w_ok;
    a_ok = 1'b0;
    w_ok = 1'b0;
    s_axi_awaddr  <= {i, 2'b00};
    s_axi_wdata   <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid  <= 1'b1;
    s_axi_bready  <= 1'b1;
    while (!(a_ok && w_ok)) begin
      @(posedge aclk);
      if (!a_ok && s_axi_awready) begin
        a_ok = 1'b1;
        s_axi_awvalid <= 1'b0;
      end
      if (!w_ok && s_axi_wready) begin
        w_ok = 1'b1;
        s_axi_wvalid <= 1'b0;
      end
    end
    do @(posedge aclk); while (!s_axi_bvalid);
    s_axi_bready <= 1'b0;
    r = s_axi_bresp;
    @(posedge aclk);
  endtask

  // read with a late rready so the answer has to stand
  task automatic rd(input logic [9:0] i, output logic [31:0] d);
    s_axi_araddr  <= {i, 2'b00};
    s_axi_arvalid <= 1'b1;
    do @(posedge aclk); while (!s_axi_arready);
    s_axi_arvalid <= 1'b0;
    repeat (2) @(posedge aclk);
    s_axi_rready <= 1'b1;
    do @(posedge aclk); while (!s_axi_rvalid);
    s_axi_rready <= 1'b0;
    d = s_axi_rdata;
    r = s_axi_rresp;
    @(posedge aclk);
  endtask

  task automatic rc(input logic [9:0] i, input logic [31:0] e);
    rd(i, v);
    chk(v, e);
  endtask

  task automatic wrap_up;
    if (n_mismatch == 0 && n_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // watchdog
  initial begin
    repeat (60000) @(posedge aclk);
    n_mismatch++;
    wrap_up();
  end

  // ==========================================================
  // tests
  initial begin
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    chk(32'({timer_irq, wake_req, irq}), 32'h0000_0000);
    for (int t = 0; t < NUM_TMR; t++) begin
      rc(ix(t, SLOT_PSC), 32'h0000_007f);
      rc(ix(t, SLOT_CNT), 32'h0000_00ff);
      rc(ix(t, SLOT_CTL), 32'h0000_0000);
    end
    // unmapped places answer with an error
    rc(10'h000, 32'h0000_0000);
    chk(32'(r), 32'(RESP_SLVERR));
    wr(10'h3ff, 32'h0000_00ff);
    chk(32'(r), 32'(RESP_SLVERR));
    // stopped timer holds count, prescaler ignores loads
    wr(IDX_A_CTL, 32'h0000_0020);
    wr(IDX_A_CNT, 32'h0000_0010);
    wr(IDX_A_PSC, 32'h0000_0005);
    repeat (300) @(posedge aclk);
    rc(IDX_A_CNT, 32'h0000_0010);
    rc(IDX_A_PSC, 32'h0000_007f);
    // running prescaler takes loads, slowest tap
    wr(IDX_A_CTL, 32'h0000_002f);
    wr(IDX_A_PSC, 32'h0000_0005);
    rd(IDX_A_PSC, v);
    chk(32'(v == 32'h0000_0005 || v == 32'h0000_0004), 32'h0000_0001);
    wr(IDX_A_PSC, 32'h0000_00ff);
    rd(IDX_A_PSC, v);
    chk(32'(v == 32'h0000_007f || v == 32'h0000_007e), 32'h0000_0001);
    rc(IDX_A_CNT, 32'h0000_0010);
    wr(IDX_A_CTL, 32'h0000_0020);
    // each timer, each tap: two counts to zero take 24 times the factor
    for (int t = 0; t < NUM_TMR; t++) begin
      for (int p = 0; p < 8; p++) begin
        wr(ix(t, SLOT_CNT), 32'h0000_0002);
        wr(ix(t, SLOT_CTL), 32'h0000_0068 | 32'(p));
        k = 0;
        while (!timer_irq[t] && k < 24 * (2 ** p) + 100) begin
          @(posedge aclk);
          k++;
        end
        chk(32'(k >= 24 * (2 ** p) - 16 && k <= 24 * (2 ** p) + 4), 32'h0000_0001);
        chk(32'(timer_irq[1 - t]), 32'h0000_0000);
        rc(ix(t, SLOT_CTL), 32'h0000_00e8 | 32'(p));
        wr(ix(t, SLOT_CTL), 32'h0000_0020);
        chk(32'(timer_irq), 32'h0000_0000);
      end
    end
    // sticky status, mask and summary line
    rc(IDX_IRQ_STAT, 32'h0000_0003);
    wr(IDX_IRQ_MASK, 32'h0000_0001);
    repeat (2) @(posedge aclk);
    chk(32'(irq), 32'h0000_0001);
    wr(IDX_IRQ_STAT, 32'h0000_0001);
    repeat (2) @(posedge aclk);
    chk(32'(irq), 32'h0000_0000);
    rc(IDX_IRQ_STAT, 32'h0000_0002);
    wr(IDX_IRQ_STAT, 32'h0000_0002);
    wr(IDX_IRQ_MASK, 32'h0000_0003);
    // flag set by software writes
    wr(IDX_A_CTL, 32'h0000_00e0);
    chk(32'(timer_irq), 32'h0000_0001);
    repeat (2) @(posedge aclk);
    chk(32'(irq), 32'h0000_0001);
    wr(IDX_A_CTL, 32'h0000_0060);
    chk(32'(timer_irq), 32'h0000_0000);
    wr(IDX_A_CNT, 32'h0000_0000);
    rc(IDX_A_CTL, 32'h0000_00e0);
    wr(IDX_A_CTL, 32'h0000_00a0);
    chk(32'(timer_irq), 32'h0000_0000);
    rc(IDX_IRQ_STAT, 32'h0000_0001);
    // count writes every fourth cycle, four phases against the 12-cycle tick;
    // only the phase where each decrement meets a write keeps the flag clear
    k = 0;
    for (int o = 0; o < 4; o++) begin
      wr(IDX_B_CNT, 32'h0000_0040);
      wr(IDX_B_CTL, 32'h0000_0028);
      repeat (o) @(posedge aclk);
      repeat (6) wr(IDX_B_CNT, 32'h0000_0001);
      rd(IDX_B_CTL, v);
      if (!v[7]) begin
        k++;
      end
      // pad each pass to 40 cycles so the phase steps by one
      repeat (3 - o) @(posedge aclk);
    end
    chk(32'(k), 32'h0000_0001);
    wrap_up();
  end
endmodule

bind dpt_timer_top dpt_timer_checker chk_i (
  .aclk, .aresetn, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
  .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
  .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .timer_irq, .wake_req
);
